// ===== bench/oaf_bank_asserts.sv
// Checker for oaf_bank outputs, tied to register reads.
// Assumes one clock domain; bound to every oaf_bank.
`timescale 1ns/1ps
module oaf_chk (
	input wire        ref_clk_i,
	input wire        rst_n_i,
	input wire        reg_rd_i,
	input wire [7:0]  reg_addr_i,
	input wire [7:0]  reg_rdata_o,
	input wire        irq_n_o,
	input wire        prox_mode_o,
	input wire        use_pilot_current_o,
	input wire        external_clock_select_o,
	input wire        dynamic_power_down_o,
	input wire        sensor_power_down_o,
	input wire [15:0] slot_types_o
);
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_pilot; use_pilot_current_o == prox_mode_o; endproperty
	a_pilot: assert property (p_pilot) else $error("pilot current");
	property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_lost; reg_rd_i && reg_addr_i == 8'h05 |=> reg_rdata_o[7:5] == 3'h0; endproperty
	a_lost: assert property (p_lost) else $error("lost count width");
	property p_ptr; reg_rd_i && reg_addr_i == 8'h04 |=> reg_rdata_o[7:5] == 3'h0; endproperty
	a_ptr: assert property (p_ptr) else $error("write index width");
	property p_slot; reg_rd_i && reg_addr_i == 8'h09 |=> reg_rdata_o == slot_types_o[7:0]; endproperty
	a_slot: assert property (p_slot) else $error("slot types");
	property p_sys; reg_rd_i && reg_addr_i == 8'h0D |=> !reg_rdata_o[0] &&
		reg_rdata_o[4:3] == {external_clock_select_o, dynamic_power_down_o}; endproperty
	a_sys: assert property (p_sys) else $error("system control");
	property p_sdirq; sensor_power_down_o |=> irq_n_o; endproperty
	a_sdirq: assert property (p_sdirq) else $error("irq in shutdown");
	property p_sdst; sensor_power_down_o && reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00; endproperty
	a_sdst: assert property (p_sdst) else $error("status in shutdown");
endmodule // oaf_chk
bind oaf_bank oaf_chk chk_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i),
	.reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .irq_n_o(irq_n_o),
	.prox_mode_o(prox_mode_o), .use_pilot_current_o(use_pilot_current_o),
	.external_clock_select_o(external_clock_select_o),
	.dynamic_power_down_o(dynamic_power_down_o),
	.sensor_power_down_o(sensor_power_down_o), .slot_types_o(slot_types_o));

// ===== bench/oaf_host.sv
// Host model on the byte-wide register strobes.
// Assumes strobes are taken on the rising edge of ref_clk_i.
`timescale 1ns/1ps
module oaf_host (
	input  wire       ref_clk_i,
	input  wire [7:0] reg_rdata_i,
	output reg        reg_wr_o,
	output reg        reg_rd_o,
	output reg  [7:0] reg_addr_o,
	output reg  [7:0] reg_wdata_o
);
	// Idle lines at time zero
	initial begin
		{reg_wr_o, reg_rd_o} = 2'h0;
		{reg_addr_o, reg_wdata_o} = 16'hFFFF;
	end
	// One access held for one edge; released lines show the inverse
	task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
		begin
			@(posedge ref_clk_i);
			#1;
			{reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = {a, d, w, !w};
			@(posedge ref_clk_i);
			#1;
			q = reg_rdata_i;
			{reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = {~a, ~d, 2'h0};
		end
	endtask
endmodule // oaf_host

// ===== bench/tb_top.sv
// Self-checking bench for oaf_bank: registers, sample queue, flags.
// Assumes oaf_host drives the register strobes.
`timescale 1ns/1ps
module tb_top;
	reg         clk, rst_n, push, s_end, e_vld, amb, head, dlow, abad;
	reg  [7:0]  sdata, v;
	reg  [18:0] expo;
	wire        wr_s, rd, irq_n;
	wire [7:0]  addr, wdata, rdata;
	integer     errors, cmp_count, i;
	oaf_host h_u (.ref_clk_i(clk), .reg_rdata_i(rdata), .reg_wr_o(wr_s), .reg_rd_o(rd),
		.reg_addr_o(addr), .reg_wdata_o(wdata));
	oaf_bank #(.SUPPLY_CYC(20)) dut_u (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr_s),
		.reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.sample_push_i(push), .sample_data_i(sdata), .sample_end_i(s_end),
		.led1_exposure_i(expo), .exposure_valid_i(e_vld), .prox_threshold_i(8'h02),
		.ambient_overflow_i(amb), .led_headroom_low_i(head), .digital_supply_low_i(dlow),
		.analog_supply_bad_i(abad), .irq_n_o(irq_n), .prox_mode_o(), .use_pilot_current_o(),
		.external_clock_select_o(), .dynamic_power_down_o(), .sensor_power_down_o(),
		.acquire_enable_o(), .slot_types_o());
	// Compare one byte
	task chk(input string n, input [7:0] e, input [7:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		h_u.acc(1'b1, a, d, v);
	endtask
	task rchk(input [7:0] a, input [7:0] e);
		begin
			h_u.acc(1'b0, a, 8'h00, v);
			chk($sformatf("reg %h", a), e, v);
		end
	endtask
	// Push n samples; data encodes the queue slot from position p
	task pushn(input integer n, input [4:0] p);
		integer j;
		for (j = 0; j < n; j = j + 1) begin
			@(posedge clk);
			#1;
			{push, sdata} = {1'b1, 3'b010, p + j[4:0]};
			@(posedge clk);
			#1;
			push = 1'b0;
		end
	endtask
	task expose(input [18:0] x);
		begin
			@(posedge clk);
			#1;
			{expo, e_vld} = {x, 1'b1};
			@(posedge clk);
			#1;
			e_vld = 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	task stop_test;
		begin
			if (errors == 0 && cmp_count > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge clk);
		errors = errors + 1;
		stop_test;
	end
	// Test sequence
	initial begin
		{rst_n, push, s_end, e_vld, amb, head, dlow, abad, sdata, expo} = 35'h0;
		{errors, cmp_count} = 64'h0;
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (i = 0; i < 14; i = i + 1)
			if (i != 7)
				rchk(i, (i == 8) ? 8'h0F : 8'h00);
		wr(8'h09, 8'h21);
		rchk(8'h09, 8'h21);
		wr(8'h0A, 8'hC3);
		rchk(8'h0A, 8'hC3);
		wr(8'h05, 8'hFF);
		rchk(8'h05, 8'h00);
		wr(8'h02, 8'hC0);
		wr(8'h0D, 8'h04);
		pushn(17, 0);
		chk("irq", 8'h00, {7'h00, irq_n});
		rchk(8'h00, 8'hC0);
		chk("irq", 8'h01, {7'h00, irq_n});
		rchk(8'h04, 8'h11);
		pushn(17, 17);
		rchk(8'h04, 8'h00);
		rchk(8'h05, 8'h02);
		rchk(8'h07, 8'h40);
		rchk(8'h06, 8'h01);
		wr(8'h08, 8'h4F);
		h_u.acc(1'b0, 8'h00, 8'h00, v);
		pushn(1, 0);
		rchk(8'h07, 8'h41);
		h_u.acc(1'b0, 8'h00, 8'h00, v);
		chk("new flag", 8'h00, v & 8'h40);
		wr(8'h08, 8'h1F);
		pushn(2, 1);
		rchk(8'h04, 8'h03);
		rchk(8'h06, 8'h03);
		rchk(8'h07, 8'h43);
		pushn(32, 3);
		rchk(8'h05, 8'h1F);
		wr(8'h06, 8'h05);
		rchk(8'h07, 8'h45);
		wr(8'h0D, 8'h00);
		pushn(1, 0);
		rchk(8'h04, 8'h03);
		wr(8'h0D, 8'h04);
		rchk(8'h04, 8'h00);
		rchk(8'h06, 8'h00);
		wr(8'h02, 8'h00);
		expose(19'd0);
		chk("prox off", 8'h00, {7'h00, dut_u.prox_mode_o});
		wr(8'h02, 8'h10);
		h_u.acc(1'b0, 8'h00, 8'h00, v);
		expose(19'd4095);
		chk("prox on", 8'h01, {7'h00, dut_u.prox_mode_o});
		expose(19'd4096);
		chk("prox exit", 8'h00, {7'h00, dut_u.prox_mode_o});
		rchk(8'h00, 8'h10);
		wr(8'h02, 8'h28);
		{amb, head} = 2'h3;
		repeat (4) @(posedge clk);
		#1;
		s_end = 1'b1;
		@(posedge clk);
		#1;
		s_end = 1'b0;
		repeat (3) @(posedge clk);
		rchk(8'h00, 8'h28);
		rchk(8'h00, 8'h00);
		{amb, head, dlow} = 3'h1;
		repeat (4) @(posedge clk);
		rchk(8'h00, 8'h01);
		dlow = 1'b0;
		wr(8'h03, 8'h80);
		abad = 1'b1;
		repeat (12) @(posedge clk);
		rchk(8'h01, 8'h00);
		repeat (14) @(posedge clk);
		rchk(8'h01, 8'h80);
		rchk(8'h01, 8'h00);
		repeat (20) @(posedge clk);
		rchk(8'h01, 8'h80);
		abad = 1'b0;
		wr(8'h0D, 8'h1A);
		amb = 1'b1;
		repeat (4) @(posedge clk);
		chk("irq", 8'h01, {7'h00, irq_n});
		rchk(8'h00, 8'h00);
		rchk(8'h0D, 8'h1A);
		wr(8'h0D, 8'h01);
		rchk(8'h00, 8'h01);
		rchk(8'h08, 8'h0F);
		stop_test;
	end
endmodule // tb_top

// ===== verilog/oaf_bank.v
// Interrupt flags, 32-entry sample FIFO and system control of the optical AFE.
// Assumes register strobes and analog event inputs; async inputs synchronised here.
`timescale 1ns/1ps
`include "oaf_defines.vh"
module oaf_bank #(
	parameter SUPPLY_CYC = `OAF_SUPPLY_CYC
) (
	input  wire        ref_clk_i,
	input  wire        rst_n_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	output reg  [7:0]  reg_rdata_o,
	input  wire        sample_push_i,
	input  wire [7:0]  sample_data_i,
	input  wire        sample_end_i,
	input  wire [18:0] led1_exposure_i,
	input  wire        exposure_valid_i,
	input  wire [7:0]  prox_threshold_i,
	input  wire        ambient_overflow_i,
	input  wire        led_headroom_low_i,
	input  wire        digital_supply_low_i,
	input  wire        analog_supply_bad_i,
	output wire        irq_n_o,
	output reg         prox_mode_o,
	output wire        use_pilot_current_o,
	output wire        external_clock_select_o,
	output wire        dynamic_power_down_o,
	output wire        sensor_power_down_o,
	output wire        acquire_enable_o,
	output wire [15:0] slot_types_o
);
	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	reg  [3:0] sync1_r;
	reg  [3:0] sync2_r;
	reg  [3:0] sync3_r;
	wire [3:0] rise_w = sync2_r & ~sync3_r;
	// Two flops on each async analog event, third for edge detect
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			sync3_r <= 4'h0;
		end else begin
			sync1_r <= {analog_supply_bad_i, digital_supply_low_i,
				led_headroom_low_i, ambient_overflow_i};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end
	// ------------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------------
	reg  [7:0] en_main_r;
	reg  [7:0] en_supply_r;
	reg  [7:0] qcfg_r;
	reg  [7:0] slot_lo_r;
	reg  [7:0] slot_hi_r;
	reg  [7:0] sysctl_r;
	wire       wr_w     = reg_wr_i;
	wire       soft_rst = wr_w && reg_addr_i == `OAF_A_SYSCTL && reg_wdata_i[`OAF_B_RST];
	wire       fen_set  = wr_w && reg_addr_i == `OAF_A_SYSCTL && reg_wdata_i[`OAF_B_FEN]
		&& !sysctl_r[`OAF_B_FEN];
	wire       shutdown_bit     = sysctl_r[`OAF_B_SHUTDOWN_BIT];
	wire       prox_en  = en_main_r[`OAF_B_PROX];
	// Writable registers; soft reset restores power-on values
	always @(posedge ref_clk_i) begin
		if (!rst_n_i || soft_rst) begin
			en_main_r   <= 8'h00;
			en_supply_r <= 8'h00;
			qcfg_r      <= `OAF_QCFG_RST;
			slot_lo_r   <= 8'h00;
			slot_hi_r   <= 8'h00;
			sysctl_r    <= 8'h00;
		end else if (wr_w) begin
			case (reg_addr_i)
			`OAF_A_EN_MAIN:   en_main_r   <= reg_wdata_i & 8'hF8;
			`OAF_A_EN_SUPPLY: en_supply_r <= reg_wdata_i & 8'h80;
			`OAF_A_QCFG:      qcfg_r      <= reg_wdata_i & 8'h7F;
			`OAF_A_SLOT_LO:   slot_lo_r   <= reg_wdata_i;
			`OAF_A_SLOT_HI:   slot_hi_r   <= reg_wdata_i;
			`OAF_A_SYSCTL:    sysctl_r    <= reg_wdata_i & 8'h1E;
			default:          sysctl_r    <= sysctl_r;
			endcase
		end
	end
	assign slot_types_o            = {slot_hi_r, slot_lo_r};
	assign external_clock_select_o = sysctl_r[`OAF_B_EXTCLK];
	assign dynamic_power_down_o    = sysctl_r[`OAF_B_LP];
	assign sensor_power_down_o     = shutdown_bit;
	assign acquire_enable_o        = sysctl_r[`OAF_B_FEN] && !shutdown_bit;
	// ------------------------------------------------------------------------
	// Proximity mode
	// ------------------------------------------------------------------------
	wire [18:0] prox_limit = {prox_threshold_i, 11'h000};
	wire        below      = led1_exposure_i < prox_limit;
	wire        prox_exit  = prox_mode_o && exposure_valid_i && !below;
	// Mode follows exposure; masked enable forces normal mode
	always @(posedge ref_clk_i) begin
		if (!rst_n_i || soft_rst) begin
			prox_mode_o <= 1'b0;
		end else if (!prox_en) begin
			prox_mode_o <= 1'b0;
		end else if (exposure_valid_i) begin
			prox_mode_o <= below;
		end
	end
	assign use_pilot_current_o = prox_mode_o;
	// ------------------------------------------------------------------------
	// FIFO storage and pointers
	// ------------------------------------------------------------------------
	reg  [7:0] mem_r [0:31];
	reg  [4:0] wr_idx_r;
	reg  [4:0] rd_idx_r;
	reg  [5:0] count_r;
	reg  [4:0] lost_r;
	wire       full     = count_r == `OAF_DEPTH;
	wire       data_rd  = reg_rd_i && reg_addr_i == `OAF_A_DATA;
	wire       pop      = data_rd && count_r != 6'h00;
	wire       push_req = sample_push_i && sysctl_r[`OAF_B_FEN] && !shutdown_bit;
	wire       wrap     = qcfg_r[`OAF_B_WRAP] || prox_mode_o;
	wire       push     = push_req && (!full || wrap);
	wire       over     = push_req && full;
	genvar gi;
	// One storage slot per entry, written at the write index
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_mem
			always @(posedge ref_clk_i) begin
				if (!rst_n_i) begin
					mem_r[gi] <= 8'h00;
				end else if (push && wr_idx_r == gi) begin
					mem_r[gi] <= sample_data_i;
				end
			end
		end
	endgenerate
	// Pointer, fill count and lost-sample count update
	always @(posedge ref_clk_i) begin
		if (!rst_n_i || soft_rst || fen_set) begin
			wr_idx_r <= 5'h00;
			rd_idx_r <= 5'h00;
			count_r  <= 6'h00;
			lost_r   <= 5'h00;
		end else begin
			if (wr_w && reg_addr_i == `OAF_A_WR_IDX) begin
				wr_idx_r <= reg_wdata_i[4:0];
			end else if (push) begin
				wr_idx_r <= wr_idx_r + 5'h01;
			end
			if (wr_w && reg_addr_i == `OAF_A_RD_IDX) begin
				rd_idx_r <= reg_wdata_i[4:0];
			end else if (push && full) begin
				rd_idx_r <= rd_idx_r + 5'h01;
			end else if (pop) begin
				rd_idx_r <= rd_idx_r + 5'h01;
			end
			if (wr_w && (reg_addr_i == `OAF_A_WR_IDX || reg_addr_i == `OAF_A_RD_IDX)) begin
				count_r <= {1'b0, (reg_addr_i == `OAF_A_WR_IDX ? reg_wdata_i[4:0] : wr_idx_r)
					- (reg_addr_i == `OAF_A_RD_IDX ? reg_wdata_i[4:0] : rd_idx_r)};
			end else if (push && !full && !pop) begin
				count_r <= count_r + 6'h01;
			end else if (pop && !push) begin
				count_r <= count_r - 6'h01;
			end
			if (over && lost_r != `OAF_LOST_MAX) begin
				lost_r <= lost_r + 5'h01;
			end
		end
	end
	// ------------------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------------------
	reg  [7:0] stat_main_r;
	reg        stat_supply_r;
	reg        afull_seen_r;
	reg [31:0] supply_cnt_r;
	wire       stat_rd   = reg_rd_i && reg_addr_i == `OAF_A_STAT_MAIN;
	wire       stat2_rd  = reg_rd_i && reg_addr_i == `OAF_A_STAT_SUPPLY;
	wire       clr_rd    = data_rd && qcfg_r[`OAF_B_CLRRD];
	wire [5:0] afull_lvl = `OAF_DEPTH - {2'b00, qcfg_r[3:0]};
	wire       afull_now = (full ? count_r : count_r + {5'h00, push && !pop}) >= afull_lvl;
	wire       afull_ev  = push && afull_now
		&& (!qcfg_r[`OAF_B_ATYPE] || !afull_seen_r);
	wire       supply_ev = supply_cnt_r == SUPPLY_CYC - 1;
	// Sticky flags: set wins over clear, shutdown clears all
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			stat_main_r   <= 8'h00;
			stat_supply_r <= 1'b0;
			afull_seen_r  <= 1'b0;
			supply_cnt_r  <= 32'h0;
		end else if (shutdown_bit && !soft_rst) begin
			// Soft reset still raises the power-up flag while shut down
			stat_main_r   <= 8'h00;
			stat_supply_r <= 1'b0;
			afull_seen_r  <= 1'b0;
			supply_cnt_r  <= 32'h0;
		end else begin
			afull_seen_r <= push ? afull_now : (afull_seen_r && afull_now);
			supply_cnt_r <= (!sync2_r[3] || supply_ev) ? 32'h0 : supply_cnt_r + 32'h1;
			stat_main_r[`OAF_B_AFULL] <= afull_ev
				|| (stat_main_r[`OAF_B_AFULL] && !stat_rd && !clr_rd);
			stat_main_r[`OAF_B_NEW] <= (push && en_main_r[`OAF_B_NEW])
				|| (stat_main_r[`OAF_B_NEW] && !stat_rd && !clr_rd);
			stat_main_r[`OAF_B_AMB] <= rise_w[0]
				|| (stat_main_r[`OAF_B_AMB] && !stat_rd);
			stat_main_r[`OAF_B_PROX] <= prox_exit
				|| (stat_main_r[`OAF_B_PROX] && !stat_rd);
			stat_main_r[`OAF_B_HEAD] <= (sample_end_i && sync2_r[1] && en_main_r[`OAF_B_HEAD])
				|| (stat_main_r[`OAF_B_HEAD] && !stat_rd);
			stat_main_r[`OAF_B_PWR] <= rise_w[2] || soft_rst
				|| (stat_main_r[`OAF_B_PWR] && !stat_rd);
			stat_main_r[2:1] <= 2'b00;
			stat_supply_r <= supply_ev || (stat_supply_r && !stat2_rd);
		end
	end
	// Active-low interrupt from any enabled flag
	assign irq_n_o = !(|(stat_main_r & en_main_r)
		|| (stat_supply_r && en_supply_r[`OAF_B_SUPPLY]));
	// ------------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------------
	// Registered read data; data port returns entry at read index
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
			`OAF_A_STAT_MAIN:   reg_rdata_o <= stat_main_r;
			`OAF_A_STAT_SUPPLY: reg_rdata_o <= {stat_supply_r, 7'h00};
			`OAF_A_EN_MAIN:     reg_rdata_o <= en_main_r;
			`OAF_A_EN_SUPPLY:   reg_rdata_o <= en_supply_r;
			`OAF_A_WR_IDX:      reg_rdata_o <= {3'b000, wr_idx_r};
			`OAF_A_LOST:        reg_rdata_o <= {3'b000, lost_r};
			`OAF_A_RD_IDX:      reg_rdata_o <= {3'b000, rd_idx_r};
			`OAF_A_DATA:        reg_rdata_o <= mem_r[rd_idx_r];
			`OAF_A_QCFG:        reg_rdata_o <= qcfg_r;
			`OAF_A_SLOT_LO:     reg_rdata_o <= slot_lo_r;
			`OAF_A_SLOT_HI:     reg_rdata_o <= slot_hi_r;
			`OAF_A_SYSCTL:      reg_rdata_o <= sysctl_r;
			default:            reg_rdata_o <= 8'h00;
			endcase
		end
	end
endmodule // oaf_bank

// ===== verilog/oaf_defines.vh
// Constants for the optical front end interrupt, FIFO and system-control bank.
// Assumes a single 40 MHz clock and a simple byte-wide register port.
// Function
// - New-sample flag sets on push when enabled, clears on reads
// - Ambient overflow flag sets, clears on status read
// - Proximity flag; masked means proximity mode disabled
// - Headroom fault flag at sample end when enabled
// - Power-up flag on undervoltage or soft reset
// - Supply range flag after 10ms, retriggers
// - Exposure below threshold times 2048 means proximity
// - Proximity uses pilot current, single LED1 exposure
// - Proximity flag raised on leaving proximity mode
// - Write index advances per pushed sample
// - Lost sample count saturates at 0x1F
// - Read index advances per pop, host writable
// - Data port read-only, reads pop samples
// - Data-read clear option also clears almost-full
// - Almost-full repeats per sample or fires once
// - Wrap on full overwrites, both indexes advance
// - No wrap on full discards, index holds
// - Proximity mode always wraps on full
// - Almost-full at 32 minus threshold unread samples
// - Four 4-bit slot type fields, reset zero
// - Clock select picks internal or external clock
// - Low-power powers sensor down between samples
// - FIFO enable set flushes; clear holds contents
// - Shutdown clears all interrupt flags
`ifndef OAF_DEFINES_VH
`define OAF_DEFINES_VH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OAF_A_STAT_MAIN   8'h00
`define OAF_A_STAT_SUPPLY 8'h01
`define OAF_A_EN_MAIN     8'h02
`define OAF_A_EN_SUPPLY   8'h03
`define OAF_A_WR_IDX      8'h04
`define OAF_A_LOST        8'h05
`define OAF_A_RD_IDX      8'h06
`define OAF_A_DATA        8'h07
`define OAF_A_QCFG        8'h08
`define OAF_A_SLOT_LO     8'h09
`define OAF_A_SLOT_HI     8'h0A
`define OAF_A_SYSCTL      8'h0D
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OAF_B_AFULL   7
`define OAF_B_NEW     6
`define OAF_B_AMB     5
`define OAF_B_PROX    4
`define OAF_B_HEAD    3
`define OAF_B_PWR     0
`define OAF_B_SUPPLY  7
`define OAF_B_CLRRD   6
`define OAF_B_ATYPE   5
`define OAF_B_WRAP    4
`define OAF_B_EXTCLK  4
`define OAF_B_LP      3
`define OAF_B_FEN     2
`define OAF_B_SHUTDOWN_BIT    1
`define OAF_B_RST     0
// ----------------------------------------------------------------------------
// Reset values, sizes and timing
// ----------------------------------------------------------------------------
`define OAF_QCFG_RST    8'h0F
`define OAF_DEPTH       6'h20
`define OAF_LOST_MAX    5'h1F
`define OAF_PROX_SHIFT  11
`define OAF_SUPPLY_MS   10
`define OAF_CLK_KHZ     40000
`define OAF_SUPPLY_CYC  (`OAF_SUPPLY_MS * `OAF_CLK_KHZ)
`endif
